// ==== dv/edge_source.sv ====
`timescale 1ns/1ps
module edge_source #(
  parameter int HALF = 3
) (
  // Clock
  input wire logic mclk,
  // Command from the bench
  input wire logic start,
  input wire logic [7:0] edges,
  // Pin and status
  output logic pin,
  output logic busy
);
  logic [7:0] left;
  int cnt;

  initial begin
    pin = 1'b0;
    busy = 1'b0;
    left = 8'h00;
    cnt = 0;
  end

  // Toggles the pin a given number of times, each level held HALF clocks
  always @(posedge mclk) begin
    if (start && !busy) begin
      busy <= 1'b1;
      left <= edges;
      cnt <= 0;
    end else if (busy && left == 8'h00) begin
      busy <= 1'b0;
    end else if (busy && cnt == HALF - 1) begin
      pin <= ~pin;
      left <= left - 8'h01;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import timer0_pkg::*;
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic [1:0] r;
  } row_type;
  localparam logic [ADDR_W-1:0] A_CNT = {IDX_TIMER_COUNT, 2'b00};
  localparam logic [ADDR_W-1:0] A_ICTL = {IDX_INT_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_CFG = {IDX_TIMER_CONFIG, 2'b00};
  localparam logic [ADDR_W-1:0] A_STAT = {IDX_INT_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] A_IEN = {IDX_INT_ENABLE, 2'b00};
  localparam logic [ADDR_W-1:0] A_ICLR = {IDX_INT_CLEAR, 2'b00};
  localparam logic [ADDR_W-1:0] A_NONE = 10'h3FC;
  row_type rows [11] = '{
    '{1'b0, A_CNT, 8'h00, 8'h00, RESP_OKAY}, '{1'b0, A_CFG, 8'h00, 8'h38, RESP_OKAY},
    '{1'b0, A_ICTL, 8'h00, 8'h00, RESP_OKAY}, '{1'b0, A_STAT, 8'h00, 8'h00, RESP_OKAY},
    '{1'b1, A_CFG, 8'hFF, 8'h3F, RESP_OKAY}, '{1'b1, A_CNT, 8'hA5, 8'hA5, RESP_OKAY},
    '{1'b1, A_IEN, 8'h01, 8'h01, RESP_OKAY}, '{1'b0, A_ICTL, 8'h00, 8'h20, RESP_OKAY},
    '{1'b1, A_ICTL, 8'h00, 8'h00, RESP_OKAY}, '{1'b1, A_ICLR, 8'h01, 8'h00, RESP_OKAY},
    '{1'b1, A_NONE, 8'h5A, 8'h00, RESP_SLVERR}};
  logic [7:0] ccfg [3] = '{8'h28, 8'h38, 8'h20};
  logic [7:0] cedg [3] = '{8'h05, 8'h05, 8'h08};
  logic [7:0] cexp [3] = '{8'h03, 8'h03, 8'h02};
  logic mclk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, ext_count_pin, sleep, wdt_tick, wdt_prescaled, irq, start, busy;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] edges;
  int num_errors = 0;
  int tests_run = 0;
  int cyc, wdt_seen, t0, w0;

  timer0_counter_prescaler DUT (
    .mclk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .ext_count_pin, .sleep, .wdt_tick, .wdt_prescaled, .irq
  );
  edge_source u_src (.mclk, .start, .edges, .pin(ext_count_pin), .busy);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (wdt_prescaled) wdt_seen <= wdt_seen + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Timing figures are only known to one count either way
  task automatic near(input string what, input logic [7:0] dc, input logic [31:0] e);
    check(what, {31'h0, ({24'h0, dc} + 32'h1 >= e) && ({24'h0, dc} <= e + 32'h1)}, 32'h1);
  endtask
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done && n < 100) begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) done = 1'b1;
    end
    resp = s_axi_bresp;
    if (!done) num_errors++;
  endtask
  task automatic axi_rd(input logic [ADDR_W-1:0] a);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done && n < 100) begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) done = 1'b1;
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    if (!done) num_errors++;
  endtask
  task automatic rate_chk(input string what, input int per, input int span);
    logic [7:0] c1;
    int t1;
    axi_rd(A_CNT);
    c1 = rd[7:0];
    t1 = cyc;
    repeat (span) @(posedge mclk);
    axi_rd(A_CNT);
    near(what, rd[7:0] - c1, (cyc - t1) / per);
  endtask
  task automatic pulse(input logic [7:0] n);
    int k;
    k = 0;
    edges <= n;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    @(posedge mclk);
    while (busy && k < 500) begin
      @(posedge mclk);
      k++;
    end
    repeat (12) @(posedge mclk);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      wdt_tick <= 1'b1;
      @(posedge mclk);
      wdt_tick <= 1'b0;
      @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sleep, wdt_tick, start} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = '1;
    edges = 8'h00;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) axi_wr(rows[i].a, rows[i].d);
      if (rows[i].wr) check("write resp", {30'h0, resp}, {30'h0, rows[i].r});
      axi_rd(rows[i].a);
      check("read data", rd, {24'h0, rows[i].e});
      check("read resp", {30'h0, resp}, {30'h0, rows[i].r});
    end
    axi_wr(A_CFG, 8'h08);
    rate_chk("timer rate", 4, 40);
    axi_wr(A_CNT, 8'h10);
    t0 = cyc;
    axi_rd(A_CNT);
    check("count after write", rd, 32'h10);
    repeat (20) @(posedge mclk);
    axi_rd(A_CNT);
    near("count after inhibit", rd[7:0] - 8'h10, (cyc - t0) / 4 - 2);
    for (int n = 0; n < 8; n++) begin
      axi_wr(A_CFG, 8'(n));
      rate_chk("prescaled rate", 4 << (n + 1), 16 << (n + 1));
    end
    axi_wr(A_CFG, 8'h08);
    axi_wr(A_ICTL, 8'h00);
    axi_wr(A_CNT, 8'hFE);
    repeat (24) @(posedge mclk);
    axi_rd(A_STAT);
    check("flag after overflow", rd, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    axi_wr(A_IEN, 8'h01);
    repeat (2) @(posedge mclk);
    check("irq enabled", {31'h0, irq}, 32'h1);
    axi_wr(A_ICLR, 8'h01);
    repeat (2) @(posedge mclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    axi_rd(A_ICTL);
    check("control cleared", rd, 32'h20);
    sleep <= 1'b1;
    axi_wr(A_CNT, 8'h40);
    repeat (40) @(posedge mclk);
    axi_rd(A_CNT);
    check("count in sleep", rd, 32'h40);
    sleep <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      axi_wr(A_CFG, ccfg[i]);
      axi_wr(A_CNT, 8'h00);
      repeat (12) @(posedge mclk);
      pulse(cedg[i]);
      axi_rd(A_CNT);
      check("pin count", rd, {24'h0, cexp[i]});
    end
    w0 = wdt_seen;
    ticks(8);
    check("watchdog unassigned", wdt_seen - w0, 32'h0);
    axi_wr(A_CFG, 8'h08);
    w0 = wdt_seen;
    ticks(8);
    near("watchdog prescaled", 8'(wdt_seen - w0), 4);
    end_of_test();
  end

  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
endmodule

// ==== dv/timer0_chk.sv ====
`timescale 1ns/1ps
module timer0_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [timer0_pkg::DATA_W-1:0] s_axi_rdata,
  // Core side
  input wire logic sleep,
  input wire logic wdt_prescaled,
  input wire logic irq
);
  import timer0_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response withdrawn early");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write response not two cycles after address and data");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write accepted while response pending");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read data not one cycle after address");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed before rready");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read address accepted while data pending");
  // A write can still raise the flag in sleep, so bus activity is excused
  property p_sleep_irq;
    $rose(irq) |-> !($past(sleep, 2) && $past(sleep, 3) && !$past(s_axi_bvalid, 1)
      && !$past(s_axi_bvalid, 2));
  endproperty
  a_sleep_irq: assert property (p_sleep_irq)
    else $error("interrupt raised by counting during sleep");
  property p_wdt_pulse;
    wdt_prescaled |=> !wdt_prescaled;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse)
    else $error("watchdog pulse longer than one cycle");
endmodule

bind timer0_counter_prescaler timer0_chk u_chk (
  .mclk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .sleep, .wdt_prescaled, .irq
);

// ==== hw/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Asynchronous level in, synchronised level out
  input wire logic din,
  output logic dout
);

  logic stage1;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule

// ==== hw/prescaler.sv ====
`timescale 1ns/1ps
module prescaler (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Events to divide and clear
  input wire logic count_event,
  input wire logic clear,
  // Tap select and divided level
  input wire logic [timer0_pkg::PS_W-1:0] ratio_sel,
  output logic tap
);
  import timer0_pkg::*;

  logic [PRESCALE_W-1:0] stages;
  logic [PRESCALE_W-1:0] toggle;

  // Each stage toggles when all lower stages are high, as in a ripple chain;
  // every stage is a square wave, so the tap is symmetrical
  assign toggle[0] = count_event;
  genvar i;
  generate
    for (i = 1; i < PRESCALE_W; i = i + 1) begin : g_chain
      assign toggle[i] = toggle[i-1] & stages[i-1];
    end
    for (i = 0; i < PRESCALE_W; i = i + 1) begin : g_stage
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          stages[i] <= 1'b0;
        end else if (clear) begin
          stages[i] <= 1'b0;
        end else if (toggle[i]) begin
          stages[i] <= ~stages[i];
        end
      end
    end
  endgenerate

  // Tap n gives a division of two to the power n+1
  assign tap = stages[ratio_sel];

endmodule

// ==== hw/timer0_counter_prescaler.sv ====
`timescale 1ns/1ps
module timer0_counter_prescaler (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [timer0_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [timer0_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [timer0_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [timer0_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // External count pin
  input wire logic ext_count_pin,
  // Core sleep state
  input wire logic sleep,
  // Watchdog side of the shared prescaler
  input wire logic wdt_tick,
  output logic wdt_prescaled,
  // Interrupt
  output logic irq
);
  import timer0_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode shared by read and write paths
  function automatic reg_sel_type decode_reg(input logic [ADDR_W-1:0] addr);
    reg_sel_type sel;
    case (addr[ADDR_W-1:2])
      IDX_TIMER_COUNT: sel = SEL_COUNT;
      IDX_INT_CTRL: sel = SEL_ICTL;
      IDX_TIMER_CONFIG: sel = SEL_CFG;
      IDX_INT_STATUS: sel = SEL_STAT;
      IDX_INT_ENABLE: sel = SEL_IEN;
      IDX_INT_CLEAR: sel = SEL_ICLR;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] timer_count;
  logic [5:0] timer_config;
  logic [PS_W-1:0] ratio_sel;
  logic [1:0] phase, inhibit;
  logic overflow_flag, overflow_int_enable;
  logic clock_source_select, source_edge_select, prescaler_assign;
  logic cycle_tick, pin_level, pin_adj, pin_adj_d, pin_rise;
  logic src_event, presc_event, presc_clear, tap, tap_d, tap_rise, presc_out;
  logic sampled, sync_pulse, timer_event, inc_event, overflow;
  wr_state_type wr_state;
  rd_state_type rd_state;
  logic aw_held, w_held, wstrb0_q, do_write;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q, next_rdata;
  reg_sel_type wr_sel, rd_sel;
  logic wr_count, wr_ictl, wr_cfg, wr_ien, wr_iclr;
  logic [1:0] next_rresp;

  assign clock_source_select = timer_config[CFG_CS_BIT];
  assign source_edge_select = timer_config[CFG_SE_BIT];
  assign prescaler_assign = timer_config[CFG_PSA_BIT];
  assign ratio_sel = timer_config[CFG_PS_LSB +: PS_W];

  ////////////////////////////////////////////////////////////////////////////////
  // Phase clock: four mclk quarters make one instruction cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase <= PHASE_Q1;
    end else begin
      phase <= 2'(phase + 2'h1);
    end
  end

  assign cycle_tick = (phase == PHASE_Q4);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin input and edge selection
  pin_sync u_pin_sync (
    .mclk(mclk),
    .nrst(nrst),
    .din(ext_count_pin),
    .dout(pin_level)
  );

  // Inverting the pin makes the falling edge the counted rising edge
  assign pin_adj = pin_level ^ source_edge_select;

  // Edge history resets to the idle level of the adjusted pin, so reset makes no false edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_adj_d <= TIMER_CONFIG_RESET[CFG_SE_BIT];
    end else begin
      pin_adj_d <= pin_adj;
    end
  end

  assign pin_rise = pin_adj & ~pin_adj_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Shared prescaler
  assign src_event = clock_source_select ? pin_rise : cycle_tick;
  // Counter side freezes in sleep; the watchdog side keeps running
  assign presc_event = prescaler_assign ? wdt_tick : (src_event & ~sleep);
  // A count write restarts the division when the prescaler is ours
  assign presc_clear = wr_count & ~prescaler_assign;

  // The stage count has no register address and no read path
  prescaler u_prescaler (
    .mclk(mclk),
    .nrst(nrst),
    .count_event(presc_event),
    .clear(presc_clear),
    .ratio_sel(ratio_sel),
    .tap(tap)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tap_d <= 1'b0;
    end else begin
      tap_d <= tap;
    end
  end

  assign tap_rise = tap & ~tap_d;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wdt_prescaled <= 1'b0;
    end else begin
      wdt_prescaled <= prescaler_assign & tap_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Phase sampler for the external path
  assign presc_out = prescaler_assign ? pin_adj : tap;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sampled <= TIMER_CONFIG_RESET[CFG_SE_BIT];
      sync_pulse <= 1'b0;
    end else if (phase == PHASE_Q2 || phase == PHASE_Q4) begin
      sampled <= presc_out;
      sync_pulse <= presc_out & ~sampled;
    end else begin
      sync_pulse <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Count and increment
  assign timer_event = prescaler_assign ? cycle_tick : tap_rise;
  assign inc_event = ~sleep & (inhibit == 2'h0) &
                     (clock_source_select ? sync_pulse : timer_event);
  assign overflow = inc_event & ~wr_count & (timer_count == COUNT_MAX);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer_count <= TIMER_COUNT_RESET;
    end else if (wr_count) begin
      timer_count <= wdata_q[7:0];
    end else if (inc_event) begin
      timer_count <= 8'(timer_count + 8'h01);
    end
  end

  // Two instruction-cycle boundaries pass before counting resumes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      inhibit <= 2'h0;
    end else if (wr_count) begin
      inhibit <= INHIBIT_CYCLES;
    end else if (cycle_tick && inhibit != 2'h0) begin
      inhibit <= 2'(inhibit - 2'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer_config <= TIMER_CONFIG_RESET;
    end else if (wr_cfg) begin
      timer_config <= wdata_q[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Overflow flag, enable and interrupt
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      overflow_flag <= OVF_FLAG_RESET;
    end else if (overflow) begin
      overflow_flag <= 1'b1;
    end else if (wr_ictl) begin
      overflow_flag <= wdata_q[ICTL_FLAG_BIT];
    end else if (wr_iclr && wdata_q[IRQ_OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      overflow_int_enable <= OVF_ENABLE_RESET;
    end else if (wr_ictl) begin
      overflow_int_enable <= wdata_q[ICTL_EN_BIT];
    end else if (wr_ien) begin
      overflow_int_enable <= wdata_q[IRQ_OVF_BIT];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= overflow_flag & overflow_int_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  assign s_axi_awready = (wr_state == WR_IDLE) & ~aw_held;
  assign s_axi_wready = (wr_state == WR_IDLE) & ~w_held;
  assign s_axi_bvalid = (wr_state == WR_RESP);
  assign do_write = (wr_state == WR_IDLE) & aw_held & w_held;
  assign wr_sel = decode_reg(awaddr_q);
  assign wr_count = do_write & wstrb0_q & (wr_sel == SEL_COUNT);
  assign wr_ictl = do_write & wstrb0_q & (wr_sel == SEL_ICTL);
  assign wr_cfg = do_write & wstrb0_q & (wr_sel == SEL_CFG);
  assign wr_ien = do_write & wstrb0_q & (wr_sel == SEL_IEN);
  assign wr_iclr = do_write & wstrb0_q & (wr_sel == SEL_ICLR);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      w_held <= 1'b0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb0_q <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_state <= WR_IDLE;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      case (wr_state)
        WR_IDLE: begin
          if (do_write) begin
            wr_state <= WR_RESP;
            s_axi_bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= WR_IDLE;
          end
        end
        default: wr_state <= WR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  assign s_axi_arready = (rd_state == RD_IDLE);
  assign s_axi_rvalid = (rd_state == RD_DATA);
  assign rd_sel = decode_reg(s_axi_araddr);

  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    case (rd_sel)
      SEL_COUNT: next_rdata[7:0] = timer_count;
      SEL_ICTL: begin
        next_rdata[ICTL_EN_BIT] = overflow_int_enable;
        next_rdata[ICTL_FLAG_BIT] = overflow_flag;
      end
      SEL_CFG: next_rdata[5:0] = timer_config;
      SEL_STAT: next_rdata[IRQ_OVF_BIT] = overflow_flag;
      SEL_IEN: next_rdata[IRQ_OVF_BIT] = overflow_int_enable;
      SEL_ICLR: next_rdata = '0;
      default: next_rresp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_state <= RD_IDLE;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state <= RD_DATA;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
          end
        end
        RD_DATA: begin
          if (s_axi_rready) begin
            rd_state <= RD_IDLE;
          end
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

endmodule

// ==== hw/timer0_pkg.sv ====
package timer0_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TIMER_COUNT = 8'h01;
  localparam logic [IDX_W-1:0] IDX_INT_CTRL = 8'h0B;
  localparam logic [IDX_W-1:0] IDX_TIMER_CONFIG = 8'h81;
  localparam logic [IDX_W-1:0] IDX_INT_STATUS = 8'hC0;
  localparam logic [IDX_W-1:0] IDX_INT_ENABLE = 8'hC1;
  localparam logic [IDX_W-1:0] IDX_INT_CLEAR = 8'hC2;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CFG_CS_BIT = 5;
  localparam int CFG_SE_BIT = 4;
  localparam int CFG_PSA_BIT = 3;
  localparam int CFG_PS_LSB = 0;
  localparam int PS_W = 3;
  localparam int ICTL_EN_BIT = 5;
  localparam int ICTL_FLAG_BIT = 2;
  localparam int IRQ_OVF_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] TIMER_COUNT_RESET = 8'h00;
  localparam logic [5:0] TIMER_CONFIG_RESET = 6'h38;
  localparam logic OVF_FLAG_RESET = 1'b0;
  localparam logic OVF_ENABLE_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
  localparam int PRESCALE_W = 8;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus responses and states
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_type;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_type;

  typedef enum logic [6:0] {
    SEL_NONE = 7'b0000001,
    SEL_COUNT = 7'b0000010,
    SEL_ICTL = 7'b0000100,
    SEL_CFG = 7'b0001000,
    SEL_STAT = 7'b0010000,
    SEL_IEN = 7'b0100000,
    SEL_ICLR = 7'b1000000
  } reg_sel_type;

endpackage
